/* File: etb_pkg.sv */
`default_nettype none
package etb_pkg;
    // Timebase: one tick per millisecond at a 4 ns clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_PERIOD_PS = 1000000000;
    localparam int MS_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;

    localparam int MS_CNT_W = 12;
    localparam int DEBOUNCE_MS = 5;
    localparam logic [MS_CNT_W-1:0] PULSE_MIN_MS = 12'h014;     // 20 ms
    localparam logic [MS_CNT_W-1:0] SAVE_HOLD_MS = 12'h7d0;     // 2000 ms
    localparam logic [MS_CNT_W-1:0] TEACH_SAMPLE_MS = 12'h1f4;  // 500 ms
    localparam logic [MS_CNT_W-1:0] LOCKOUT_MS = 12'h032;       // 50 ms
    localparam int BLINK_HALF_LOG2 = 7;
    localparam int LED_CNT_W = 10;
    localparam logic [LED_CNT_W-1:0] BLINK_LAST_MS = 10'h3ff;

    localparam int MAX_SENSORS = 16;
    localparam int COUNT_W = 5;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_TEACH_FULL = 4'h1,
        CMD_TEACH_LIM_MINUS = 4'h2,
        CMD_TEACH_LIM_PLUS = 4'h3,
        CMD_TEACH_TWO_LEVEL = 4'h4,
        CMD_LOCK_ON = 4'h5,
        CMD_LOCK_OFF = 4'h6,
        CMD_BANK_LOAD = 4'h7,
        CMD_BANK_SAVE = 4'h8
    } etb_cmd_t;

    // Teach table index is {held past 500 ms, select_line_b, select_line_a}
    typedef etb_cmd_t [7:0] etb_map_t;
    localparam etb_map_t DEF_TEACH_MAP = '{
        CMD_TEACH_TWO_LEVEL, CMD_TEACH_LIM_PLUS, CMD_TEACH_LIM_MINUS, CMD_TEACH_FULL,
        CMD_TEACH_TWO_LEVEL, CMD_LOCK_OFF, CMD_LOCK_ON, CMD_NONE
    };

    typedef enum logic [1:0] {
        SHIFT_NONE = 2'h0,
        SHIFT_BELOW = 2'h1,
        SHIFT_ABOVE = 2'h2
    } etb_shift_t;

    typedef struct packed {
        logic valid;
        etb_cmd_t cmd;
        logic [1:0] bank;
        logic level;
        etb_shift_t shift;
    } etb_cmd_pkt_t;

    typedef struct packed {
        logic mode;
        logic sel_b;
        logic sel_a;
        logic timing;
    } etb_in_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_LOCK = 2'b11,
        ST_RELEASE = 2'b10
    } etb_state_t;

    typedef enum logic [1:0] {
        LED_OFF = 2'b00,
        LED_BLINK = 2'b01,
        LED_ON = 2'b11
    } etb_led_t;

    // One bit per attached amplifier; counts above 16 saturate
    function automatic logic [MAX_SENSORS-1:0] dest_mask(input logic [COUNT_W-1:0] n);
        logic [MAX_SENSORS:0] m;
        m = ((MAX_SENSORS + 1)'(1) << n) - (MAX_SENSORS + 1)'(1);
        return m[MAX_SENSORS-1:0];
    endfunction : dest_mask

    function automatic etb_shift_t shift_of(input etb_cmd_t c);
        case (c)
            CMD_TEACH_LIM_MINUS: return SHIFT_BELOW;
            CMD_TEACH_LIM_PLUS: return SHIFT_ABOVE;
            default: return SHIFT_NONE;
        endcase
    endfunction : shift_of
endpackage : etb_pkg
`default_nettype wire

/* File: etb_ms_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module etb_ms_tick #(
    parameter int CYC_PER_MS = etb_pkg::MS_CYCLES
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    output logic tick_o
);
    localparam int CW = $clog2(CYC_PER_MS);

    if (CYC_PER_MS < 2) begin : g_bad_cycles
        $error("etb_ms_tick: CYC_PER_MS must be at least 2");
    end

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_tick = (cnt_ff == CW'(CYC_PER_MS - 1));
        nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule : etb_ms_tick
`default_nettype wire

/* File: etb_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module etb_debounce #(
    parameter int WIDTH = 4,
    parameter int STABLE_MS = etb_pkg::DEBOUNCE_MS
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic tick_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    localparam int CW = $clog2(STABLE_MS + 1);

    if (WIDTH < 1 || STABLE_MS < 1) begin : g_bad_params
        $error("etb_debounce: WIDTH and STABLE_MS must be at least 1");
    end

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] q_ff;
    logic [WIDTH-1:0] nxt_q;
    logic [WIDTH-1:0][CW-1:0] cnt_ff;
    logic [WIDTH-1:0][CW-1:0] nxt_cnt;

    // A bit follows its input only after it has differed for STABLE_MS ticks
    always_comb begin
        nxt_q = q_ff;
        nxt_cnt = cnt_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync_ff[i] == q_ff[i]) begin
                nxt_cnt[i] = '0;
            end else if (tick_i) begin
                if (cnt_ff[i] == CW'(STABLE_MS - 1)) begin
                    nxt_q[i] = sync_ff[i];
                    nxt_cnt[i] = '0;
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
            q_ff <= '0;
            cnt_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
            q_ff <= nxt_q;
            cnt_ff <= nxt_cnt;
        end
    end

    assign q_o = q_ff;
endmodule : etb_debounce
`default_nettype wire

/* File: etb_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode wire level picks teach/key-lock commands or data bank commands.
// - Sinking variant: mode high or open means bank, low means teaching.
// - Select lines give the operation; timing line gives moment and duration.
// - Bank mode: timing pulse from 20 ms to under 2 s loads the bank.
// - Bank mode: timing held 2 s or more saves the bank.
// - Full-auto and limit teaching need at least 0.5 s hold; sampling starts after 0.5 s.
// - Two-level teach: two pulses of 20 ms to under 2 s, one per level.
// - After each accepted operation, commands are ignored for about 50 ms.
// - Sourcing variant inverts every input including the mode wire.
// - Teaching set has full-auto, limit minus, limit plus and two-level.
// - Teaching set also switches the sensors' key lock on and off.
// - Bank commands address one of three channels, all sensors at once.
// - Each command is broadcast to up to 16 attached amplifiers.
// - Indicator blinks then steady after save/full-auto; steady after every other command.
// - Limit minus puts threshold below measured light by the shift amount.
// - Limit plus puts threshold above measured light by the shift amount.
module etb_decoder #(
    parameter int MS_CYCLES = etb_pkg::MS_CYCLES
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic mode_line_i,
    input wire logic select_line_a_i,
    input wire logic select_line_b_i,
    input wire logic timing_line_i,
    input wire logic sourcing_variant_i,
    input wire logic [etb_pkg::COUNT_W-1:0] sensor_count_i,
    input wire etb_pkg::etb_map_t teach_map_i,
    output var etb_pkg::etb_cmd_pkt_t cmd_o,
    output logic [etb_pkg::MAX_SENSORS-1:0] cmd_dest_o,
    output logic sampling_o,
    output logic tx_led_o,
    output logic key_lock_o,
    output logic bank_mode_o,
    output logic busy_o
);
    etb_pkg::etb_in_t raw_in;
    etb_pkg::etb_in_t clean_in;
    logic tick;

    // Polarity is undone before synchronising so both variants share one path
    assign raw_in = {mode_line_i, select_line_b_i, select_line_a_i, timing_line_i}
        ^ {4{sourcing_variant_i}};

    etb_ms_tick #(
        .CYC_PER_MS(MS_CYCLES)
    ) u_tick (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    etb_debounce #(
        .WIDTH(4),
        .STABLE_MS(etb_pkg::DEBOUNCE_MS)
    ) u_debounce (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick),
        .d_i(raw_in),
        .q_o(clean_in)
    );

    etb_pkg::etb_state_t state_ff;
    etb_pkg::etb_state_t nxt_state;
    logic [etb_pkg::MS_CNT_W-1:0] ms_ff;
    logic [etb_pkg::MS_CNT_W-1:0] nxt_ms;
    logic mode_ff;
    logic nxt_mode;
    logic sampling_ff;
    logic nxt_sampling;
    logic level_ff;
    logic nxt_level;
    logic key_lock_ff;
    logic nxt_key_lock;
    logic bank_mode_ff;
    logic busy_ff;
    etb_pkg::etb_cmd_pkt_t cmd_ff;
    etb_pkg::etb_cmd_pkt_t nxt_cmd;
    logic [etb_pkg::MAX_SENSORS-1:0] dest_ff;
    logic [etb_pkg::MAX_SENSORS-1:0] nxt_dest;
    etb_pkg::etb_cmd_t issue;
    etb_pkg::etb_cmd_t pick;
    logic [2:0] idx;
    logic [1:0] sel;

    // Operation decoder and pulse timer
    always_comb begin
        nxt_state = state_ff;
        nxt_ms = ms_ff;
        nxt_mode = mode_ff;
        nxt_sampling = sampling_ff;
        nxt_level = level_ff;
        nxt_key_lock = key_lock_ff;
        nxt_dest = dest_ff;
        nxt_cmd = '0;
        issue = etb_pkg::CMD_NONE;
        sel = {clean_in.sel_b, clean_in.sel_a};
        idx = {ms_ff >= etb_pkg::TEACH_SAMPLE_MS, sel};
        pick = teach_map_i[idx];
        if (tick && ms_ff != etb_pkg::SAVE_HOLD_MS) begin
            nxt_ms = ms_ff + 1'b1;
        end
        case (state_ff)
            etb_pkg::ST_IDLE: begin
                nxt_ms = '0;
                if (clean_in.timing) begin
                    nxt_state = etb_pkg::ST_HOLD;
                    nxt_mode = clean_in.mode;
                end
            end
            etb_pkg::ST_HOLD: begin
                if (!clean_in.timing) begin
                    nxt_state = etb_pkg::ST_IDLE;
                    nxt_sampling = 1'b0;
                    if (ms_ff >= etb_pkg::PULSE_MIN_MS) begin
                        if (mode_ff) begin
                            if (ms_ff < etb_pkg::SAVE_HOLD_MS && sel != 2'h0) begin
                                issue = etb_pkg::CMD_BANK_LOAD;
                            end
                        end else if (!(pick == etb_pkg::CMD_TEACH_TWO_LEVEL
                                && ms_ff >= etb_pkg::SAVE_HOLD_MS)) begin
                            issue = pick;
                        end
                    end
                end else if (mode_ff) begin
                    if (tick && ms_ff == etb_pkg::SAVE_HOLD_MS - 1'b1 && sel != 2'h0) begin
                        issue = etb_pkg::CMD_BANK_SAVE;
                    end
                end else if (tick && ms_ff == etb_pkg::TEACH_SAMPLE_MS - 1'b1) begin
                    nxt_sampling = 1'b1;
                end
                if (issue != etb_pkg::CMD_NONE) begin
                    nxt_state = etb_pkg::ST_LOCK;
                    nxt_ms = '0;
                    nxt_sampling = 1'b0;
                end
            end
            etb_pkg::ST_LOCK: begin
                // Timing line is ignored until the lockout has fully run
                if (tick && ms_ff == etb_pkg::LOCKOUT_MS) begin
                    nxt_state = etb_pkg::ST_RELEASE;
                end
            end
            etb_pkg::ST_RELEASE: begin
                if (!clean_in.timing) begin
                    nxt_state = etb_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = etb_pkg::ST_IDLE;
            end
        endcase
        if (issue != etb_pkg::CMD_NONE) begin
            nxt_cmd.valid = 1'b1;
            nxt_cmd.cmd = issue;
            nxt_cmd.bank = mode_ff ? sel : 2'h0;
            nxt_cmd.shift = etb_pkg::shift_of(issue);
            nxt_cmd.level = (issue == etb_pkg::CMD_TEACH_TWO_LEVEL) ? level_ff : 1'b0;
            nxt_level = (issue == etb_pkg::CMD_TEACH_TWO_LEVEL) ? !level_ff : 1'b0;
            nxt_dest = etb_pkg::dest_mask(sensor_count_i);
            if (issue == etb_pkg::CMD_LOCK_ON) begin
                nxt_key_lock = 1'b1;
            end else if (issue == etb_pkg::CMD_LOCK_OFF) begin
                nxt_key_lock = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_ff <= etb_pkg::ST_IDLE;
            ms_ff <= '0;
            mode_ff <= 1'b0;
            sampling_ff <= 1'b0;
            level_ff <= 1'b0;
            key_lock_ff <= 1'b0;
            bank_mode_ff <= 1'b0;
            busy_ff <= 1'b0;
            cmd_ff <= '0;
            dest_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            ms_ff <= nxt_ms;
            mode_ff <= nxt_mode;
            sampling_ff <= nxt_sampling;
            level_ff <= nxt_level;
            key_lock_ff <= nxt_key_lock;
            bank_mode_ff <= clean_in.mode;
            busy_ff <= (nxt_state == etb_pkg::ST_LOCK);
            cmd_ff <= nxt_cmd;
            dest_ff <= nxt_dest;
        end
    end

    etb_pkg::etb_led_t led_st_ff;
    etb_pkg::etb_led_t nxt_led_st;
    logic [etb_pkg::LED_CNT_W-1:0] led_ms_ff;
    logic [etb_pkg::LED_CNT_W-1:0] nxt_led_ms;
    logic led_ff;
    logic nxt_led;

    // Transmission indicator
    always_comb begin
        nxt_led_st = led_st_ff;
        nxt_led_ms = led_ms_ff;
        nxt_led = led_ff;
        case (led_st_ff)
            etb_pkg::LED_OFF: begin
                nxt_led = 1'b0;
            end
            etb_pkg::LED_BLINK: begin
                if (tick) begin
                    nxt_led_ms = led_ms_ff + 1'b1;
                    nxt_led = !nxt_led_ms[etb_pkg::BLINK_HALF_LOG2];
                    if (led_ms_ff == etb_pkg::BLINK_LAST_MS) begin
                        nxt_led_st = etb_pkg::LED_ON;
                        nxt_led = 1'b1;
                    end
                end
            end
            etb_pkg::LED_ON: begin
                nxt_led = 1'b1;
            end
            default: begin
                nxt_led_st = etb_pkg::LED_OFF;
                nxt_led = 1'b0;
            end
        endcase
        if (state_ff == etb_pkg::ST_IDLE && clean_in.timing) begin
            nxt_led_st = etb_pkg::LED_OFF;
            nxt_led = 1'b0;
        end
        if (nxt_cmd.valid) begin
            nxt_led_ms = '0;
            nxt_led = 1'b1;
            if (issue == etb_pkg::CMD_BANK_SAVE || issue == etb_pkg::CMD_TEACH_FULL) begin
                nxt_led_st = etb_pkg::LED_BLINK;
            end else begin
                nxt_led_st = etb_pkg::LED_ON;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            led_st_ff <= etb_pkg::LED_OFF;
            led_ms_ff <= '0;
            led_ff <= 1'b0;
        end else begin
            led_st_ff <= nxt_led_st;
            led_ms_ff <= nxt_led_ms;
            led_ff <= nxt_led;
        end
    end

    assign cmd_o = cmd_ff;
    assign cmd_dest_o = dest_ff;
    assign sampling_o = sampling_ff;
    assign tx_led_o = led_ff;
    assign key_lock_o = key_lock_ff;
    assign bank_mode_o = bank_mode_ff;
    assign busy_o = busy_ff;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_issue;
        cmd_o.valid;
    endsequence
    sequence s_locked;
        (busy_o && !cmd_o.valid) [*8];
    endsequence

    cmd_set_a: assert property (cmd_o.valid |-> mode_ff == (cmd_o.cmd inside
        {etb_pkg::CMD_BANK_LOAD, etb_pkg::CMD_BANK_SAVE}))
        else $error("command does not match latched command set");
    load_window_a: assert property (cmd_o.valid && cmd_o.cmd == etb_pkg::CMD_BANK_LOAD |->
        $past(ms_ff) >= etb_pkg::PULSE_MIN_MS && $past(ms_ff) < etb_pkg::SAVE_HOLD_MS)
        else $error("load issued outside 20 ms to 2 s window");
    save_hold_a: assert property (cmd_o.valid && cmd_o.cmd == etb_pkg::CMD_BANK_SAVE |->
        $past(ms_ff) == etb_pkg::SAVE_HOLD_MS - 1'b1 && $past(tick))
        else $error("save not issued at the 2 s mark");
    sample_start_a: assert property ($rose(sampling_o) |->
        !mode_ff && $past(ms_ff) == etb_pkg::TEACH_SAMPLE_MS - 1'b1)
        else $error("sampling did not start at 0.5 s");
    two_level_a: assert property (cmd_o.valid && cmd_o.cmd == etb_pkg::CMD_TEACH_TWO_LEVEL
        |-> cmd_o.level == $past(level_ff) && level_ff != $past(level_ff))
        else $error("two-level step did not advance");
    lockout_a: assert property (s_issue |=> s_locked)
        else $error("lockout not held after command");
    lockout_end_a: assert property ($fell(busy_o) |-> $past(ms_ff) == etb_pkg::LOCKOUT_MS)
        else $error("lockout ended early");
    bank_chan_a: assert property (cmd_o.valid && mode_ff |-> cmd_o.bank != 2'h0
        && cmd_o.bank == $past({clean_in.sel_b, clean_in.sel_a}))
        else $error("bank channel does not follow select lines");
    broadcast_a: assert property (cmd_o.valid |->
        cmd_dest_o == etb_pkg::dest_mask($past(sensor_count_i)))
        else $error("broadcast mask wrong");
    led_steady_a: assert property (cmd_o.valid && !(cmd_o.cmd inside
        {etb_pkg::CMD_BANK_SAVE, etb_pkg::CMD_TEACH_FULL}) |-> tx_led_o [*3])
        else $error("indicator not steady after command");
    shift_dir_a: assert property (cmd_o.valid |-> (cmd_o.shift == etb_pkg::SHIFT_BELOW)
        == (cmd_o.cmd == etb_pkg::CMD_TEACH_LIM_MINUS))
        else $error("shift direction wrong");
    key_lock_a: assert property (cmd_o.valid && cmd_o.cmd == etb_pkg::CMD_LOCK_ON
        |-> key_lock_o ##1 key_lock_o)
        else $error("key lock not set");
endmodule : etb_decoder
`default_nettype wire

/* File: etb_plc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module etb_plc_model #(
    parameter int MS_CYC = 10
) (
    input wire logic mclk_i,
    input wire logic sourcing_i,
    output logic mode_o,
    output logic sel_a_o,
    output logic sel_b_o,
    output logic timing_o
);
    // Logical levels; an open mode wire reads as the bank set
    logic m_bank = 1'b1;
    logic a_on = 1'b0;
    logic b_on = 1'b0;
    logic t_on = 1'b0;

    // Sourcing swaps every level, mode wire included
    assign mode_o = m_bank ^ sourcing_i;
    assign sel_a_o = a_on ^ sourcing_i;
    assign sel_b_o = b_on ^ sourcing_i;
    assign timing_o = t_on ^ sourcing_i;

    task automatic wait_ms(input int n);
        repeat (n * MS_CYC) @(negedge mclk_i);
    endtask : wait_ms

    // Selects frame the timing pulse by 10 ms on both sides
    task automatic command(input logic bank, input logic a, input logic b, input int width_ms);
        @(negedge mclk_i);
        m_bank = bank;
        a_on = a;
        b_on = b;
        wait_ms(10);
        t_on = 1'b1;
        wait_ms(width_ms);
        t_on = 1'b0;
        wait_ms(10);
        a_on = 1'b0;
        b_on = 1'b0;
    endtask : command
endmodule : etb_plc_model
`default_nettype wire

/* File: etb_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module etb_decoder_tb;
    localparam int MS_CYC = 10;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sourcing_variant_i = 1'b0;
    logic [etb_pkg::COUNT_W-1:0] sensor_count_i = 5'h00;
    logic mode_line_i;
    logic select_line_a_i;
    logic select_line_b_i;
    logic timing_line_i;
    etb_pkg::etb_cmd_pkt_t cmd_o;
    logic [etb_pkg::MAX_SENSORS-1:0] cmd_dest_o;
    logic sampling_o;
    logic tx_led_o;
    logic key_lock_o;
    logic bank_mode_o;
    logic busy_o;
    int err_count = 0;
    int checks = 0;
    etb_pkg::etb_cmd_pkt_t exp_q[$];
    etb_pkg::etb_cmd_pkt_t exp_p;
    // Teaching table: entries 0..5, select a and b as bit masks
    localparam logic [5:0] TA = 6'h1d;
    localparam logic [5:0] TB = 6'h3a;
    etb_pkg::etb_cmd_t tc[6] = '{etb_pkg::CMD_TEACH_LIM_MINUS, etb_pkg::CMD_TEACH_LIM_PLUS,
        etb_pkg::CMD_LOCK_ON, etb_pkg::CMD_TEACH_TWO_LEVEL, etb_pkg::CMD_TEACH_TWO_LEVEL,
        etb_pkg::CMD_LOCK_OFF};

    always #2 mclk_i = ~mclk_i;

    etb_decoder #(.MS_CYCLES(MS_CYC)) u_etb_decoder (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mode_line_i(mode_line_i),
        .select_line_a_i(select_line_a_i), .select_line_b_i(select_line_b_i),
        .timing_line_i(timing_line_i), .sourcing_variant_i(sourcing_variant_i),
        .sensor_count_i(sensor_count_i), .teach_map_i(etb_pkg::DEF_TEACH_MAP),
        .cmd_o(cmd_o), .cmd_dest_o(cmd_dest_o), .sampling_o(sampling_o), .tx_led_o(tx_led_o),
        .key_lock_o(key_lock_o), .bank_mode_o(bank_mode_o), .busy_o(busy_o)
    );

    etb_plc_model #(.MS_CYC(MS_CYC)) u_etb_plc_model (
        .mclk_i(mclk_i), .sourcing_i(sourcing_variant_i), .mode_o(mode_line_i),
        .sel_a_o(select_line_a_i), .sel_b_o(select_line_b_i), .timing_o(timing_line_i)
    );

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic wrap_up();
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [15:0] exp_dest();
        if (sensor_count_i >= 5'h10) return 16'hffff;
        return 16'((17'h1 << sensor_count_i) - 17'h1);
    endfunction : exp_dest

    task automatic expect_cmd(input etb_pkg::etb_cmd_t c, input logic [1:0] bk, input logic lv);
        etb_pkg::etb_cmd_pkt_t p;
        p = '0;
        p.valid = 1'b1;
        p.cmd = c;
        p.bank = bk;
        p.level = lv;
        p.shift = (c == etb_pkg::CMD_TEACH_LIM_MINUS) ? etb_pkg::SHIFT_BELOW :
            (c == etb_pkg::CMD_TEACH_LIM_PLUS) ? etb_pkg::SHIFT_ABOVE : etb_pkg::SHIFT_NONE;
        exp_q.push_back(p);
    endtask : expect_cmd

    // Wait for the lockout to end; every expected command must have shown up
    task automatic settle();
        int n;
        n = 0;
        u_etb_plc_model.wait_ms(10);
        while (busy_o !== 1'b0 && n < 800) begin
            @(negedge mclk_i);
            n++;
        end
        chk(n < 800, "lockout did not end");
        chk(exp_q.size() == 0, "command missing");
    endtask : settle

    task automatic run(input logic bank, input logic a, input logic b, input int w,
                       input etb_pkg::etb_cmd_t c, input logic [1:0] bk, input logic lv);
        if (c != etb_pkg::CMD_NONE) expect_cmd(c, bk, lv);
        u_etb_plc_model.command(bank, a, b, w);
        settle();
    endtask : run

    task automatic do_reset(input logic src);
        @(negedge mclk_i);
        sys_rst_i = 1'b1;
        sourcing_variant_i = src;
        sensor_count_i = 5'($urandom_range(20, 0));
        repeat (10) @(negedge mclk_i);
        sys_rst_i = 1'b0;
    endtask : do_reset

    always @(negedge mclk_i) begin
        if (cmd_o.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "unexpected command");
            end else begin
                exp_p = exp_q.pop_front();
                chk(cmd_o.cmd === exp_p.cmd, "command code");
                chk(cmd_o.bank === exp_p.bank, "bank channel");
                chk(cmd_o.level === exp_p.level, "level step");
                chk(cmd_o.shift === exp_p.shift, "threshold shift");
                chk(busy_o === 1'b1, "lockout with command");
            end
        end
    end

    // Planned run is about 280 us; this cuts a hang short
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hdf7f));
        do_reset(1'b0);
        for (int ch = 1; ch <= 3; ch++) begin
            run(1'b1, ch[0], ch[1], 100, etb_pkg::CMD_BANK_LOAD, 2'(ch), 1'b0);
            chk(tx_led_o === 1'b1, "indicator after load");
            chk(cmd_dest_o === exp_dest(), "broadcast mask");
            chk(bank_mode_o === 1'b1, "bank set");
        end
        run(1'b1, 1'b0, 1'b0, 100, etb_pkg::CMD_NONE, 2'h0, 1'b0);
        run(1'b1, 1'b1, 1'b0, 15, etb_pkg::CMD_NONE, 2'h0, 1'b0);
        run(1'b1, 1'b0, 1'b1, 25, etb_pkg::CMD_BANK_LOAD, 2'h2, 1'b0);
        // A pulse inside the lockout is dropped
        expect_cmd(etb_pkg::CMD_BANK_LOAD, 2'h1, 1'b0);
        u_etb_plc_model.command(1'b1, 1'b1, 1'b0, 50);
        chk(busy_o === 1'b1, "lockout running");
        u_etb_plc_model.command(1'b1, 1'b0, 1'b1, 25);
        settle();
        expect_cmd(etb_pkg::CMD_BANK_SAVE, 2'h3, 1'b0);
        u_etb_plc_model.command(1'b1, 1'b1, 1'b1, 2100);
        u_etb_plc_model.wait_ms(85);
        chk(tx_led_o === 1'b0, "indicator blink phase");
        u_etb_plc_model.wait_ms(900);
        chk(tx_led_o === 1'b1, "indicator steady after blink");
        settle();
        fork
            run(1'b0, 1'b0, 1'b0, 550, etb_pkg::CMD_TEACH_FULL, 2'h0, 1'b0);
            begin
                u_etb_plc_model.wait_ms(300);
                chk(sampling_o === 1'b0, "sampling too early");
                u_etb_plc_model.wait_ms(250);
                chk(sampling_o === 1'b1, "sampling after half second");
            end
        join
        chk(sampling_o === 1'b0, "sampling ends at release");
        chk(bank_mode_o === 1'b0, "teaching set");
        // Empty table entry: short pulse with no select gives no command
        run(1'b0, 1'b0, 1'b0, 100, etb_pkg::CMD_NONE, 2'h0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            run(1'b0, TA[i], TB[i], (i < 2) ? 550 : 100, tc[i], 2'h0, i == 4);
            chk(key_lock_o === (i >= 2 && i <= 4), "key lock state");
            chk(tx_led_o === 1'b1, "indicator steady");
        end
        do_reset(1'b1);
        run(1'b1, 1'b0, 1'b1, 100, etb_pkg::CMD_BANK_LOAD, 2'h2, 1'b0);
        chk(bank_mode_o === 1'b1, "inverted bank set");
        chk(cmd_dest_o === exp_dest(), "broadcast mask");
        run(1'b0, 1'b1, 1'b0, 100, etb_pkg::CMD_LOCK_ON, 2'h0, 1'b0);
        chk(key_lock_o === 1'b1, "inverted key lock");
        wrap_up();
    end
endmodule : etb_decoder_tb
`default_nettype wire
